/* File: design/pls_sequencer.sv */
`timescale 1ns/1ps
// Functional notes
// - Current limit runs fault timer, then latches.
// - Qualified supply-low latches; unplug or reset releases.
// - Qualified overvoltage latches; unplug or reset releases.
// - External latch request qualified per frequency option.
// - Thermal stop also kills startup source.
// - Long feedback-off sleeps; start plus feedback wakes.
// - Switching only inside latch-pin window.
// - Thermistor bias current sourced from latch pin.
// - Short latch-pin crossings are blanked.
// - Latch-pin latch clears only at supply reset.
// - Latch inputs ignored until start level.
// - Low threshold checked only after soft-start.
// - Bias current doubled during soft-start.
// - Thermal trip stops driver, enters low power.
// - Supply kept alive during thermal shutdown.
// - Thermal clear re-enables normal startup.
// - Fault timer restarts when limit drops.
// - Winding short latches with no timer.
// - Autorecovery retries after delay, else new burst.
module pls_sequencer #(
  parameter int unsigned FAULT_TIMER_CYC = pls_pkg::FAULT_TIMER_CYC,
  parameter int unsigned AUTOREC_CYC = pls_pkg::AUTOREC_CYC,
  parameter int unsigned SOFTSTART_CYC = pls_pkg::SOFTSTART_CYC,
  parameter int unsigned OFF_MODE_CYC = pls_pkg::OFF_MODE_CYC
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // Options
  input wire logic autorecovery_i,
  input wire logic fast_option_i,
  // Comparator flags
  input wire pls_pkg::pls_flags_t flags_i,
  input wire pls_pkg::pls_supply_t supply_i,
  input wire logic line_unplug_discharge_event_i,
  // Power stage control
  output pls_pkg::pls_ctrl_t ctrl_o
);
  localparam int unsigned W = pls_pkg::CNT_W;

  typedef struct packed {
    pls_pkg::pls_state_t state;
    logic [W-1:0] timer;
    logic soft_start;
    logic pin_latched;
    logic release_on_start_low;
    pls_pkg::pls_ctrl_t ctrl;
  } pls_seq_state_t;

  pls_seq_state_t st;
  pls_seq_state_t next_st;

  logic supply_low_q;
  logic supply_high_q;
  logic ext_q;
  logic thermal_q;
  logic fb_off_q;
  logic latch_high_q;
  logic latch_low_q;
  logic [W-1:0] ext_limit;

  function automatic logic [W-1:0] to_w(input int unsigned v);
    to_w = v[W-1:0];
  endfunction

  // Frequency-dependent qualification.
  assign ext_limit = fast_option_i ? to_w(pls_pkg::QUAL_EXT_FAST_CYC) : to_w(pls_pkg::QUAL_EXT_CYC);

  pls_qual_timer #(.CNT_W(W)) u_q_low (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .flag_i(flags_i.supply_low),
    .limit_i(to_w(pls_pkg::QUAL_SUPPLY_CYC)),
    .qualified_o(supply_low_q)
  );
  pls_qual_timer #(.CNT_W(W)) u_q_high (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .flag_i(flags_i.supply_high),
    .limit_i(to_w(pls_pkg::QUAL_SUPPLY_CYC)),
    .qualified_o(supply_high_q)
  );
  pls_qual_timer #(.CNT_W(W)) u_q_ext (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .flag_i(flags_i.ext_latch),
    .limit_i(ext_limit),
    .qualified_o(ext_q)
  );
  pls_qual_timer #(.CNT_W(W)) u_q_tsd (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .flag_i(flags_i.thermal_shutdown),
    .limit_i(to_w(pls_pkg::QUAL_THERMAL_CYC)),
    .qualified_o(thermal_q)
  );
  pls_qual_timer #(.CNT_W(W)) u_q_fb (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .flag_i(flags_i.feedback_off),
    .limit_i(to_w(OFF_MODE_CYC)),
    .qualified_o(fb_off_q)
  );
  pls_qual_timer #(.CNT_W(W)) u_b_high (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .flag_i(flags_i.latch_high),
    .limit_i(to_w(pls_pkg::BLANK_HIGH_CYC)),
    .qualified_o(latch_high_q)
  );
  pls_qual_timer #(.CNT_W(W)) u_b_low (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .flag_i(flags_i.latch_low),
    .limit_i(to_w(pls_pkg::BLANK_LOW_CYC)),
    .qualified_o(latch_low_q)
  );

  always_comb begin
    next_st = st;
    case (st.state)
      pls_pkg::PLS_OFF: begin
        next_st.timer = '0;
        if (supply_i.above_start_level && !latch_high_q && !st.pin_latched) begin
          next_st.state = pls_pkg::PLS_RUN;
          next_st.soft_start = 1'b1;
        end
      end
      pls_pkg::PLS_RUN: begin
        if (st.soft_start) begin
          if (st.timer + 1'b1 >= to_w(SOFTSTART_CYC)) begin
            next_st.soft_start = 1'b0;
            next_st.timer = '0;
          end else begin
            next_st.timer = st.timer + 1'b1;
          end
        end else if (flags_i.at_current_limit) begin
          next_st.timer = st.timer + 1'b1;
        end else begin
          next_st.timer = '0;
        end
        if (thermal_q) begin
          next_st.state = pls_pkg::PLS_THERMAL;
          next_st.timer = '0;
        end else if (latch_high_q || (latch_low_q && !st.soft_start)) begin
          next_st.state = pls_pkg::PLS_LATCH;
          next_st.pin_latched = 1'b1;
          next_st.release_on_start_low = 1'b0;
        end else if (ext_q) begin
          next_st.state = pls_pkg::PLS_LATCH;
          next_st.release_on_start_low = 1'b1;
        end else if (supply_low_q || supply_high_q) begin
          next_st.state = pls_pkg::PLS_LATCH;
          next_st.release_on_start_low = 1'b0;
        end else if (flags_i.winding_short ||
                     (!st.soft_start && flags_i.at_current_limit && st.timer + 1'b1 >= to_w(FAULT_TIMER_CYC))) begin
          next_st.state = autorecovery_i ? pls_pkg::PLS_AUTOREC : pls_pkg::PLS_LATCH;
          next_st.release_on_start_low = 1'b0;
          next_st.timer = '0;
        end else if (fb_off_q) begin
          next_st.state = pls_pkg::PLS_SLEEP;
        end
      end
      pls_pkg::PLS_LATCH: begin
        next_st.timer = '0;
        // pin latch clears only at supply reset
        if (supply_i.below_reset_level) begin
          next_st.state = pls_pkg::PLS_OFF;
          next_st.pin_latched = 1'b0;
        end else if (!st.pin_latched && (line_unplug_discharge_event_i ||
                     (st.release_on_start_low && !supply_i.above_start_level))) begin
          next_st.state = pls_pkg::PLS_OFF;
        end
      end
      pls_pkg::PLS_AUTOREC: begin
        if (line_unplug_discharge_event_i || supply_i.below_reset_level ||
            st.timer + 1'b1 >= to_w(AUTOREC_CYC)) begin
          next_st.state = pls_pkg::PLS_OFF;
          next_st.timer = '0;
        end else begin
          next_st.timer = st.timer + 1'b1;
        end
      end
      pls_pkg::PLS_THERMAL: begin
        if (supply_i.above_start_level && flags_i.thermal_fault_clear) begin
          next_st.state = pls_pkg::PLS_OFF;
        end
      end
      pls_pkg::PLS_SLEEP: begin
        if (supply_i.above_start_level && flags_i.feedback_on) begin
          next_st.state = pls_pkg::PLS_OFF;
        end
      end
      default: begin
        next_st.state = pls_pkg::PLS_OFF;
      end
    endcase
    // driver held off outside run; soft-start on every start
    if (next_st.state != pls_pkg::PLS_RUN) begin
      next_st.soft_start = 1'b0;
    end
    next_st.ctrl.gate_drive_out = (next_st.state == pls_pkg::PLS_RUN);
    next_st.ctrl.soft_start = next_st.soft_start;
    next_st.ctrl.thermistor_bias_current = (next_st.state == pls_pkg::PLS_RUN);
    next_st.ctrl.thermistor_boost_current = next_st.soft_start;
    // startup source off in thermal stop
    next_st.ctrl.startup_source_en = (next_st.state != pls_pkg::PLS_THERMAL);
    // supply kept in thermal; cut in sleep
    next_st.ctrl.internal_supply_en = (next_st.state != pls_pkg::PLS_SLEEP);
    next_st.ctrl.latched = (next_st.state == pls_pkg::PLS_LATCH);
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st <= '{state: pls_pkg::PLS_OFF, timer: '0, soft_start: 1'b0, pin_latched: 1'b0,
              release_on_start_low: 1'b0,
              ctrl: '{gate_drive_out: 1'b0, soft_start: 1'b0, thermistor_bias_current: 1'b0,
                      thermistor_boost_current: 1'b0, startup_source_en: 1'b1,
                      internal_supply_en: 1'b1, latched: 1'b0}};
    end else begin
      st <= next_st;
    end
  end

  assign ctrl_o = st.ctrl;
endmodule // pls_sequencer

/* File: design/pls_pkg.sv */
package pls_pkg;
  localparam int unsigned CLK_MHZ = 100;
  // Qualification and blanking times in microseconds; off-mode time in milliseconds.
  localparam int unsigned QUAL_SUPPLY_US = 10;
  localparam int unsigned QUAL_THERMAL_US = 10;
  localparam int unsigned QUAL_EXT_US = 55;
  localparam int unsigned QUAL_EXT_FAST_US = 35;
  localparam int unsigned BLANK_HIGH_US = 50;
  localparam int unsigned BLANK_LOW_US = 350;
  localparam int unsigned OFF_MODE_MS = 600;
  // Cycle counts derived from the clock rate.
  localparam int unsigned QUAL_SUPPLY_CYC = QUAL_SUPPLY_US * CLK_MHZ;
  localparam int unsigned QUAL_THERMAL_CYC = QUAL_THERMAL_US * CLK_MHZ;
  localparam int unsigned QUAL_EXT_CYC = QUAL_EXT_US * CLK_MHZ;
  localparam int unsigned QUAL_EXT_FAST_CYC = QUAL_EXT_FAST_US * CLK_MHZ;
  localparam int unsigned BLANK_HIGH_CYC = BLANK_HIGH_US * CLK_MHZ;
  localparam int unsigned BLANK_LOW_CYC = BLANK_LOW_US * CLK_MHZ;
  localparam int unsigned OFF_MODE_CYC = OFF_MODE_MS * 1000 * CLK_MHZ;
  localparam int unsigned FAULT_TIMER_CYC = 128 * 1000 * CLK_MHZ;
  localparam int unsigned AUTOREC_CYC = 1000 * 1000 * CLK_MHZ;
  localparam int unsigned SOFTSTART_CYC = 10 * 1000 * CLK_MHZ;
  localparam int unsigned CNT_W = 32;

  typedef enum logic [2:0] {
    PLS_OFF,
    PLS_RUN,
    PLS_LATCH,
    PLS_AUTOREC,
    PLS_THERMAL,
    PLS_SLEEP
  } pls_state_t;

  // Comparator flags from the analog front end.
  typedef struct packed {
    logic at_current_limit;
    logic winding_short;
    logic supply_low;
    logic supply_high;
    logic latch_high;
    logic latch_low;
    logic ext_latch;
    logic thermal_shutdown;
    logic thermal_fault_clear;
    logic feedback_off;
    logic feedback_on;
  } pls_flags_t;

  // Supply level comparators.
  typedef struct packed {
    logic above_start_level;
    logic below_reset_level;
  } pls_supply_t;

  // Outputs to the power stage.
  typedef struct packed {
    logic gate_drive_out;
    logic soft_start;
    logic thermistor_bias_current;
    logic thermistor_boost_current;
    logic startup_source_en;
    logic internal_supply_en;
    logic latched;
  } pls_ctrl_t;
endpackage

/* File: design/pls_qual_timer.sv */
`timescale 1ns/1ps
// Counts while the flag holds and restarts when it drops; fires at terminal count.
module pls_qual_timer #(
  parameter int unsigned CNT_W = 32
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // Control
  input wire logic flag_i,
  input wire logic [CNT_W-1:0] limit_i,
  // Result
  output logic qualified_o
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic qualified;
  } pls_qt_state_t;

  pls_qt_state_t st;
  pls_qt_state_t next_st;

  always_comb begin
    next_st = st;
    if (!flag_i) begin
      next_st.cnt = '0;
      next_st.qualified = 1'b0;
    end else if (st.cnt + 1'b1 >= limit_i) begin
      next_st.qualified = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign qualified_o = st.qualified;
endmodule // pls_qual_timer

/* File: test/pls_checker.sv */
`timescale 1ns/1ps
module pls_checker #(
  parameter int unsigned FAULT_TIMER_CYC = 50
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // Watched ports
  input wire logic autorecovery_i,
  input wire pls_pkg::pls_flags_t flags_i,
  input wire pls_pkg::pls_supply_t supply_i,
  input wire logic line_unplug_discharge_event_i,
  input wire pls_pkg::pls_ctrl_t ctrl_o
);
  int unsigned lim_cnt;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!arst_n_i);
  // Counts cycles of current limit while the driver is on and soft-start is over.
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lim_cnt <= 0;
    end else begin
      lim_cnt <= (flags_i.at_current_limit && ctrl_o.gate_drive_out && !ctrl_o.soft_start) ? lim_cnt + 1 : 0;
    end
  end
  sequence s_short;
    ctrl_o.gate_drive_out && flags_i.winding_short;
  endsequence
  sequence s_hold;
    ctrl_o.latched && !line_unplug_discharge_event_i && !supply_i.below_reset_level
      && supply_i.above_start_level && !autorecovery_i;
  endsequence
  chk_short_stop: assert property (s_short |=> !ctrl_o.gate_drive_out)
    else $error("gate kept on after winding short");
  chk_latch_gate: assert property (ctrl_o.latched |-> !ctrl_o.gate_drive_out)
    else $error("gate on while latched");
  chk_supply_kept: assert property (!ctrl_o.startup_source_en |-> ctrl_o.internal_supply_en)
    else $error("supply dropped with startup source off");
  chk_sleep_gate: assert property (!ctrl_o.internal_supply_en |-> !ctrl_o.gate_drive_out)
    else $error("gate on while internal supply off");
  chk_boost_soft: assert property (ctrl_o.thermistor_boost_current |-> ctrl_o.soft_start
    && ctrl_o.thermistor_bias_current)
    else $error("boost current outside soft start");
  chk_soft_boost: assert property (ctrl_o.soft_start |-> ctrl_o.thermistor_boost_current)
    else $error("no boost current during soft start");
  chk_start_soft: assert property ($rose(ctrl_o.gate_drive_out) |-> ctrl_o.soft_start)
    else $error("start without soft start");
  chk_start_level: assert property ($rose(ctrl_o.gate_drive_out)
    |-> $past(supply_i.above_start_level))
    else $error("start without supply at start level");
  chk_latch_hold: assert property (s_hold |=> ctrl_o.latched)
    else $error("latch released without release condition");
  chk_fault_bound: assert property (ctrl_o.gate_drive_out |-> lim_cnt <= FAULT_TIMER_CYC + 2)
    else $error("fault timer overran");
endmodule // pls_checker
bind pls_sequencer pls_checker #(.FAULT_TIMER_CYC(FAULT_TIMER_CYC)) u_chk (
  .mclk_i(mclk_i),
  .arst_n_i(arst_n_i),
  .autorecovery_i(autorecovery_i),
  .flags_i(flags_i),
  .supply_i(supply_i),
  .line_unplug_discharge_event_i(line_unplug_discharge_event_i),
  .ctrl_o(ctrl_o)
);

/* File: test/pls_supply_model.sv */
`timescale 1ns/1ps
// Supply network: the rail charges for a while after the line is applied.
module pls_supply_model #(
  parameter int unsigned CHARGE_CYC = 4
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // Line connection
  input wire logic plugged_i,
  // Supply comparators
  output pls_pkg::pls_supply_t supply_o
);
  int unsigned charge;
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      charge <= 0;
    end else if (!plugged_i) begin
      charge <= 0;
    end else if (charge < CHARGE_CYC) begin
      charge <= charge + 1;
    end
  end
  assign supply_o.above_start_level = (charge == CHARGE_CYC);
  assign supply_o.below_reset_level = !plugged_i;
endmodule // pls_supply_model

/* File: test/protection_latch_sequencer_tb.sv */
`timescale 1ns/1ps
`define PLS_CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module protection_latch_sequencer_tb;
  typedef struct packed {
    logic [10:0] f;
    logic fast;
    int unsigned n;
    logic gate;
  } pls_row_t;
  localparam int unsigned FT = 50;
  localparam int unsigned AR = 100;
  localparam int unsigned SS = 50;
  localparam int unsigned OM = 200;
  localparam logic [10:0] BASE = 11'h005;
  localparam pls_row_t ROWS [11] = '{
    '{11'h200, 1'b0, 1, 1'b0},
    '{11'h400, 1'b0, FT + 3, 1'b0},
    '{11'h400, 1'b0, FT - 5, 1'b1},
    '{11'h100, 1'b0, pls_pkg::QUAL_SUPPLY_CYC + 3, 1'b0},
    '{11'h100, 1'b0, pls_pkg::QUAL_SUPPLY_CYC - 5, 1'b1},
    '{11'h080, 1'b0, pls_pkg::QUAL_SUPPLY_CYC + 3, 1'b0},
    '{11'h010, 1'b0, pls_pkg::QUAL_EXT_CYC + 3, 1'b0},
    '{11'h010, 1'b1, pls_pkg::QUAL_EXT_FAST_CYC + 3, 1'b0},
    '{11'h040, 1'b0, pls_pkg::BLANK_HIGH_CYC - 5, 1'b1},
    '{11'h040, 1'b0, pls_pkg::BLANK_HIGH_CYC + 3, 1'b0},
    '{11'h020, 1'b0, pls_pkg::BLANK_LOW_CYC + 3, 1'b0}
  };
  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic autorecovery_i = 1'b0;
  logic fast_option_i = 1'b0;
  logic unplug = 1'b0;
  logic plugged = 1'b0;
  logic [10:0] flags = BASE;
  pls_pkg::pls_supply_t supply;
  pls_pkg::pls_ctrl_t ctrl_o;
  int bad_count = 0;
  int n_tests = 0;
  int cycles = 0;
  pls_sequencer #(.FAULT_TIMER_CYC(FT), .AUTOREC_CYC(AR), .SOFTSTART_CYC(SS), .OFF_MODE_CYC(OM)) u_dut (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .autorecovery_i(autorecovery_i),
    .fast_option_i(fast_option_i), .flags_i(pls_pkg::pls_flags_t'(flags)), .supply_i(supply),
    .line_unplug_discharge_event_i(unplug), .ctrl_o(ctrl_o));
  pls_supply_model u_sup (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .plugged_i(plugged), .supply_o(supply));
  always #5 mclk_i = ~mclk_i;
  task automatic results();
    if (bad_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 90000) begin
      bad_count++;
      results();
    end
  end
  task automatic wait_n(int n);
    repeat (n) @(posedge mclk_i);
    @(negedge mclk_i);
  endtask
  task automatic power_cycle();
    int k = 0;
    @(posedge mclk_i);
    plugged <= 1'b0;
    repeat (3) @(posedge mclk_i);
    plugged <= 1'b1;
    while (ctrl_o.gate_drive_out !== 1'b1 && k < 50) begin
      @(negedge mclk_i);
      k++;
    end
    `PLS_CHK("boost", 2'b11, {ctrl_o.soft_start, ctrl_o.thermistor_boost_current})
    wait_n(SS + 5);
    `PLS_CHK("bias", 2'b01, {ctrl_o.thermistor_boost_current, ctrl_o.thermistor_bias_current})
  endtask
  task automatic hold(logic [10:0] f, int n);
    @(posedge mclk_i);
    flags <= BASE | f;
    repeat (n) @(posedge mclk_i);
    flags <= BASE;
    wait_n(3);
  endtask
  task automatic pulse_unplug();
    @(posedge mclk_i);
    unplug <= 1'b1;
    @(posedge mclk_i);
    unplug <= 1'b0;
    wait_n(3);
  endtask
  initial begin
    wait_n(9);
    `PLS_CHK("reset", 7'h06, ctrl_o)
    @(posedge mclk_i);
    arst_n_i <= 1'b1;
    foreach (ROWS[i]) begin
      power_cycle();
      @(posedge mclk_i);
      fast_option_i <= ROWS[i].fast;
      hold(ROWS[i].f, ROWS[i].n);
      `PLS_CHK("gate", ROWS[i].gate, ctrl_o.gate_drive_out)
      `PLS_CHK("latched", !ROWS[i].gate, ctrl_o.latched)
      // A second short spell shows the counters restarted; the short then stops the run for the next power cycle.
      if (ROWS[i].gate) begin
        hold(ROWS[i].f, ROWS[i].n);
        `PLS_CHK("gate again", 1'b1, ctrl_o.gate_drive_out)
        hold(11'h200, 1);
      end
    end
    power_cycle();
    hold(11'h040, pls_pkg::BLANK_HIGH_CYC + 3);
    pulse_unplug();
    `PLS_CHK("pin latch", 1'b1, ctrl_o.latched)
    power_cycle();
    `PLS_CHK("pin release", 1'b0, ctrl_o.latched)
    hold(11'h100, pls_pkg::QUAL_SUPPLY_CYC + 3);
    pulse_unplug();
    `PLS_CHK("unplug release", 1'b0, ctrl_o.latched)
    @(posedge mclk_i);
    autorecovery_i <= 1'b1;
    hold(11'h200, 1);
    `PLS_CHK("short stop", 1'b0, ctrl_o.gate_drive_out)
    wait_n(AR + 10);
    `PLS_CHK("retry", 2'b11, {ctrl_o.gate_drive_out, ctrl_o.soft_start})
    @(posedge mclk_i);
    autorecovery_i <= 1'b0;
    wait_n(SS + 5);
    @(posedge mclk_i);
    flags <= 11'h009;
    wait_n(pls_pkg::QUAL_THERMAL_CYC + 3);
    `PLS_CHK("thermal", 3'b001, {ctrl_o.gate_drive_out, ctrl_o.startup_source_en, ctrl_o.internal_supply_en})
    @(posedge mclk_i);
    flags <= BASE;
    wait_n(5);
    `PLS_CHK("thermal clear", 1'b1, ctrl_o.gate_drive_out)
    wait_n(SS + 5);
    @(posedge mclk_i);
    flags <= 11'h002;
    wait_n(OM + 5);
    `PLS_CHK("sleep", 2'b00, {ctrl_o.gate_drive_out, ctrl_o.internal_supply_en})
    @(posedge mclk_i);
    flags <= BASE;
    wait_n(5);
    `PLS_CHK("wake", 1'b1, ctrl_o.gate_drive_out)
    results();
  end
endmodule // protection_latch_sequencer_tb
